// [common/bsel_defs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef BSEL_DEFS_SVH
`define BSEL_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BSEL_ADR_CPC 8'h00
`define BSEL_ADR_BANK 8'h04
`define BSEL_ADR_STATUS 8'h08
`define BSEL_ADR_SECURITY 8'h0C
`define BSEL_ADR_ERASE 8'h10

// ----------------------------------------
// command codes in chip_program_control, and the erase register key
// ----------------------------------------
`define BSEL_CPC_TO_LOADER 8'h03
`define BSEL_CPC_UPDATE 8'h01
`define BSEL_CPC_SOFT_RESTART 8'h83
`define BSEL_ERASE_KEY 8'hA5

// ----------------------------------------
// security and option bit positions
// ----------------------------------------
`define BSEL_SEC_LOCK 0
`define BSEL_SEC_TREAD_INH 1
`define BSEL_SEC_REBOOT_AB 4
`define BSEL_SEC_REBOOT_C 5
`define BSEL_SEC_CLK_HIGH 7

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define BSEL_ST_LOADER 0
`define BSEL_ST_UPDATE 1
`define BSEL_ST_PROG 2
`define BSEL_ST_LOCKED 3
`define BSEL_ST_RESTART 4

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define BSEL_SEC_ERASED 8'hFF
`define BSEL_REG_RESET 8'h00
`define BSEL_CLK_MHZ 100
`define BSEL_RESTART_NS 40
`define BSEL_RESTART_CYC ((`BSEL_RESTART_NS * `BSEL_CLK_MHZ + 999) / 1000)

`endif

// [common/bsel_pkg.sv]
// types shared by the boot select block
package bsel_pkg;
	typedef logic [7:0] bsel_byte_t;
	typedef enum logic [1:0] {
		BSEL_SAMPLE,
		BSEL_RUN,
		BSEL_RESTART
	} bsel_phase_t;
	typedef struct packed {
		bsel_phase_t phase;
		logic loader;
		logic update_en;
		bsel_byte_t cpc;
		bsel_byte_t bank;
		logic [3:0] rst_cnt;
		logic idle_q;
		logic ack;
		logic [31:0] rdat;
	} bsel_state_t;
endpackage : bsel_pkg

// [common/bsel_sec_if.sv]
// link between control logic and the security bit store
`timescale 1ns/10ps
`default_nettype none
interface bsel_sec_if;
	logic wr;
	logic erase;
	logic [7:0] wdata;
	logic [7:0] bits;
	modport ctrl (output wr, output erase, output wdata, input bits);
	modport store (input wr, input erase, input wdata, output bits);
endinterface : bsel_sec_if
`default_nettype wire

// [hdl/bsel_sync.sv]
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module bsel_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} bsel_sync_t;
	bsel_sync_t st;
	bsel_sync_t next_st;

	// no reset so straps are tracked while reset is held
	always_comb begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign q = st.s2;
endmodule : bsel_sync
`default_nettype wire

// [hdl/bsel_secbits.sv]
// security and option bit store
`include "bsel_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module bsel_secbits (
	input wire logic clk,
	input wire logic rstn,
	bsel_sec_if.store sec
);
	typedef struct packed {
		logic [7:0] bits;
	} bsel_sec_t;
	bsel_sec_t st;
	bsel_sec_t next_st;

	always_comb begin
		next_st = st;
		if (sec.erase) begin
			next_st.bits = `BSEL_SEC_ERASED;
		end else if (sec.wr) begin
			// bits only move from 1 to 0
			next_st.bits = st.bits & sec.wdata;
		end
	end

	// stands in for nonvolatile cells; reset models the erased part
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st.bits <= `BSEL_SEC_ERASED;
		end else begin
			st <= next_st;
		end
	end

	assign sec.bits = st.bits;
endmodule : bsel_secbits
`default_nettype wire

// [hdl/bsel_top.sv]
// boot memory selection and code security control
`include "bsel_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module bsel_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic strap_pin_a,
	input wire logic strap_pin_b,
	input wire logic strap_pin_c,
	input wire logic writer_mode,
	input wire logic cpu_idle,
	input wire logic tread_from_external,
	output logic boot_from_loader,
	output logic core_restart,
	output logic flash_update_en,
	output logic [7:0] flash_bank_select,
	output logic tread_internal_ok,
	output logic writer_flash_ok,
	output logic clk_range_high
);
	localparam logic [3:0] RESTART_CYC = 4'(`BSEL_RESTART_CYC);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [3:0] pins_s;
	logic strap_a_s;
	logic strap_b_s;
	logic strap_c_s;
	logic prog_s;

	bsel_sync #(
		.W(4)
	) u_sync (
		.clk(clk),
		.d({writer_mode, strap_pin_c, strap_pin_b, strap_pin_a}),
		.q(pins_s)
	);

	assign strap_a_s = pins_s[0];
	assign strap_b_s = pins_s[1];
	assign strap_c_s = pins_s[2];
	assign prog_s = pins_s[3];

	// ----------------------------------------
	// security bit store
	// ----------------------------------------
	bsel_sec_if sec ();

	bsel_secbits u_sec (
		.clk(clk),
		.rstn(rstn),
		.sec(sec)
	);

	logic locked;
	logic sec_open;
	logic reboot_req;

	// lock bit low refuses security register and writer flash access
	assign locked = ~sec.bits[`BSEL_SEC_LOCK];
	assign sec_open = prog_s & ~locked;

	// reboot decision on the strap levels
	assign reboot_req =
		(~sec.bits[`BSEL_SEC_REBOOT_AB] & ~strap_a_s & ~strap_b_s)
		| (~sec.bits[`BSEL_SEC_REBOOT_C] & ~strap_c_s);

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	bsel_pkg::bsel_state_t st;
	bsel_pkg::bsel_state_t next_st;
	logic bus_req;
	logic bus_wr;
	logic bus_rd;
	logic lane0;

	// a held request is not taken again in its ack cycle
	assign bus_req = wb_cyc_i & wb_stb_i & ~st.ack;
	assign bus_wr = bus_req & wb_we_i;
	assign bus_rd = bus_req & ~wb_we_i;
	assign lane0 = wb_sel_i[0];

	logic wr_cpc;
	logic wr_bank;
	logic wr_sec;
	logic wr_erase;
	logic idle_rise;

	assign wr_cpc = bus_wr & lane0 & (wb_adr_i == `BSEL_ADR_CPC);
	assign wr_bank = bus_wr & lane0 & (wb_adr_i == `BSEL_ADR_BANK);
	assign wr_sec = bus_wr & lane0 & (wb_adr_i == `BSEL_ADR_SECURITY);
	assign wr_erase = bus_wr & lane0 & (wb_adr_i == `BSEL_ADR_ERASE);
	assign idle_rise = cpu_idle & ~st.idle_q;

	// security writes only in writer mode and while unlocked
	assign sec.wr = wr_sec & sec_open;
	assign sec.wdata = wb_dat_i[7:0];
	// erase-all is the one way back to ones, even when locked
	assign sec.erase = wr_erase & prog_s
		& (wb_dat_i[7:0] == `BSEL_ERASE_KEY);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	logic [31:0] rd_val;
	logic [7:0] status;

	always_comb begin
		status = 8'h00;
		status[`BSEL_ST_LOADER] = st.loader;
		status[`BSEL_ST_UPDATE] = st.update_en;
		status[`BSEL_ST_PROG] = prog_s;
		status[`BSEL_ST_LOCKED] = locked;
		status[`BSEL_ST_RESTART] = (st.phase == bsel_pkg::BSEL_RESTART);
		rd_val = 32'h0000_0000;
		case (wb_adr_i)
			`BSEL_ADR_CPC: begin
				rd_val[7:0] = st.cpc;
			end
			`BSEL_ADR_BANK: begin
				rd_val[7:0] = st.bank;
			end
			`BSEL_ADR_STATUS: begin
				rd_val[7:0] = status;
			end
			`BSEL_ADR_SECURITY: begin
				// outside writer mode or when locked this reads zero
				if (sec_open) begin
					rd_val[7:0] = sec.bits;
				end
			end
			default: begin
				rd_val = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------
	// control state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.idle_q = cpu_idle;
		// every address is answered, unmapped ones with zero
		next_st.ack = bus_req;
		if (bus_rd) begin
			next_st.rdat = rd_val;
		end
		case (st.phase)
			bsel_pkg::BSEL_SAMPLE: begin
				// straps have settled through the sync while reset was low
				next_st.loader = reboot_req;
				next_st.update_en = 1'b0;
				next_st.cpc = `BSEL_REG_RESET;
				next_st.bank = `BSEL_REG_RESET;
				next_st.phase = bsel_pkg::BSEL_RUN;
			end
			bsel_pkg::BSEL_RUN: begin
				if (wr_bank) begin
					next_st.bank = wb_dat_i[7:0];
				end
				if (wr_cpc && wb_dat_i[7:0] == `BSEL_CPC_SOFT_RESTART) begin
					next_st.loader = 1'b0;
					next_st.update_en = 1'b0;
					next_st.cpc = `BSEL_REG_RESET;
					next_st.bank = `BSEL_REG_RESET;
					next_st.rst_cnt = RESTART_CYC;
					next_st.phase = bsel_pkg::BSEL_RESTART;
				end else if (wr_cpc) begin
					next_st.cpc = wb_dat_i[7:0];
				end else if (idle_rise
						&& st.cpc == `BSEL_CPC_TO_LOADER) begin
					next_st.loader = 1'b1;
					next_st.update_en = 1'b1;
					next_st.cpc = `BSEL_REG_RESET;
					next_st.rst_cnt = RESTART_CYC;
					next_st.phase = bsel_pkg::BSEL_RESTART;
				end else if (idle_rise
						&& st.cpc == `BSEL_CPC_UPDATE) begin
					// update runs alongside the application, no restart
					next_st.update_en = 1'b1;
				end
			end
			bsel_pkg::BSEL_RESTART: begin
				// CPC and bank writes are dropped while the core is held
				if (st.rst_cnt <= 4'h1) begin
					next_st.rst_cnt = 4'h0;
					next_st.phase = bsel_pkg::BSEL_RUN;
				end else begin
					next_st.rst_cnt = st.rst_cnt - 4'h1;
				end
			end
			default: begin
				next_st.phase = bsel_pkg::BSEL_SAMPLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st.phase <= bsel_pkg::BSEL_SAMPLE;
			st.loader <= 1'b0;
			st.update_en <= 1'b0;
			st.cpc <= `BSEL_REG_RESET;
			st.bank <= `BSEL_REG_RESET;
			st.rst_cnt <= 4'h0;
			st.idle_q <= 1'b0;
			st.ack <= 1'b0;
			st.rdat <= 32'h0000_0000;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.rdat;
	assign boot_from_loader = st.loader;
	assign core_restart = (st.phase != bsel_pkg::BSEL_RUN);
	assign flash_update_en = st.update_en;
	assign flash_bank_select = st.bank;
	// internal code hidden only from external table reads
	assign tread_internal_ok = sec.bits[`BSEL_SEC_TREAD_INH]
		| ~tread_from_external;
	assign writer_flash_ok = prog_s & ~locked;
	// set by the programmer per crystal range; passed on as is
	assign clk_range_high = sec.bits[`BSEL_SEC_CLK_HIGH];
endmodule : bsel_top
`default_nettype wire

// [testbench/bsel_properties.sv]
// port-level checks for the boot select block
`timescale 1ns/10ps
`default_nettype none
module bsel_properties (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic strap_pin_a,
	input wire logic strap_pin_b,
	input wire logic strap_pin_c,
	input wire logic writer_mode,
	input wire logic cpu_idle,
	input wire logic tread_from_external,
	input wire logic boot_from_loader,
	input wire logic core_restart,
	input wire logic flash_update_en,
	input wire logic [7:0] flash_bank_select,
	input wire logic tread_internal_ok,
	input wire logic writer_flash_ok,
	input wire logic clk_range_high
);
	// ----
	// helpers
	// ----
	logic [2:0] up_cnt;
	logic [1:0] er_age;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			up_cnt <= 3'h0;
			er_age <= 2'h0;
		end else begin
			if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
			if (wb_ack_o && wb_we_i && wb_adr_i == 8'h10) er_age <= 2'h3;
			else if (er_age != 2'h0) er_age <= er_age - 2'h1;
		end
	end
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("no ack after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_erased_boot: assert property (up_cnt == 3'h2 |->
		clk_range_high && !boot_from_loader) else $error("bad boot state");
	a_loader_idle: assert property ($rose(boot_from_loader) |->
		$past(cpu_idle) && core_restart) else $error("loader without idle");
	// the 83h write is still held on the bus while its ack stands
	a_soft_app: assert property ($fell(boot_from_loader) |->
		core_restart && wb_ack_o && wb_we_i && wb_adr_i == 8'h00
		&& wb_dat_i[7:0] == 8'h83) else $error("app switch without restart");
	a_update_idle: assert property ($rose(flash_update_en) |->
		$past(cpu_idle)) else $error("update without idle entry");
	// erase lands at the edge that raises ack, so ack counts as recent
	a_sec_oneway: assert property ($rose(clk_range_high) |->
		er_age != 2'h0 || (wb_ack_o && wb_we_i && wb_adr_i == 8'h10))
		else $error("security bit set without erase");
	a_sec_refuse: assert property (wb_ack_o && !wb_we_i
		&& wb_adr_i == 8'h0C && !writer_flash_ok |-> wb_dat_o == 32'h0)
		else $error("security readable");
	a_tread_internal: assert property (!tread_from_external |->
		tread_internal_ok) else $error("internal table read blocked");
	a_restart_len: assert property ($rose(core_restart) |->
		core_restart [*4] ##1 !core_restart) else $error("restart length");
	a_boot_fixed: assert property ($changed(boot_from_loader) |->
		core_restart || $past(core_restart)) else $error("boot changed");
	c_reboot: cover property ($rose(boot_from_loader));
	c_soft: cover property ($fell(boot_from_loader));
	c_update: cover property ($rose(flash_update_en) && !core_restart);
endmodule : bsel_properties
`default_nettype wire

// [testbench/bsel_prog_model.sv]
// programmer and strap pin model
`timescale 1ns/10ps
`default_nettype none
module bsel_prog_model #(
	parameter int XT_MHZ = 20
) (
	input wire logic clk,
	input wire logic writer_req,
	input wire logic [2:0] strap_req,
	output logic strap_pin_a,
	output logic strap_pin_b,
	output logic strap_pin_c,
	output logic writer_mode,
	output logic [7:0] sec_word
);
	// crystal range in bit 7, table reads inhibited
	assign sec_word = {XT_MHZ > 24, 5'h1F, 2'b01};
	// straps have pull-ups, so released pins read high
	initial {strap_pin_c, strap_pin_b, strap_pin_a, writer_mode} = 4'hE;
	always @(posedge clk) begin
		{strap_pin_c, strap_pin_b, strap_pin_a} <= strap_req;
		writer_mode <= writer_req;
	end
endmodule : bsel_prog_model
`default_nettype wire

// [testbench/boot_select_and_code_security_bench.sv]
// self-checking bench for the boot select block
`timescale 1ns/10ps
`default_nettype none
module boot_select_and_code_security_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'hDC86;
	logic cpu_idle = 1'b0, tread_from_external = 1'b0, writer_req = 1'b0;
	logic strap_pin_a, strap_pin_b, strap_pin_c, writer_mode, core_restart;
	logic boot_from_loader, flash_update_en, tread_internal_ok;
	logic writer_flash_ok, clk_range_high;
	logic [7:0] flash_bank_select, sec_word;
	logic [2:0] strap_req = 3'h0;
	logic [31:0] exp_q[$];
	int errors = 0, compares = 0;
	bsel_top bsel_top_i (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .strap_pin_a,
		.strap_pin_b, .strap_pin_c, .writer_mode, .cpu_idle,
		.tread_from_external, .boot_from_loader, .core_restart,
		.flash_update_en, .flash_bank_select, .tread_internal_ok,
		.writer_flash_ok, .clk_range_high);
	bsel_prog_model bsel_prog_model_i (.clk, .writer_req, .strap_req,
		.strap_pin_a, .strap_pin_b, .strap_pin_c, .writer_mode, .sec_word);
	// ----
	// helpers
	// ----
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, s, e);
		end
	endtask : chk
	// reads note the expected byte; the monitor compares at ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		r = rnd();
		if (!w) exp_q.push_back({24'h0, d});
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {r[31:8], d};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic give_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	always @(posedge clk) begin
		if (wb_ack_o && !wb_we_i) chk(wb_dat_o, exp_q.pop_front());
	end
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (2000) @(posedge clk);
		errors++;
		give_verdict();
	end
	initial begin
		logic [31:0] v;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		// straps low, but erased reboot bits keep the application boot
		chk(boot_from_loader, 1'b0);
		chk(clk_range_high, 1'b1);
		strap_req <= 3'h7;
		wb(1'b0, 8'h0C, 8'h00);
		$display("test reset_boot done");
		// one programming session of the writer
		writer_req <= 1'b1;
		repeat (4) @(posedge clk);
		wb(1'b0, 8'h0C, 8'hFF);
		wb(1'b1, 8'h0C, sec_word);
		wb(1'b1, 8'h0C, 8'hFF);
		wb(1'b0, 8'h0C, sec_word);
		chk(clk_range_high, sec_word[7]);
		tread_from_external <= 1'b1;
		@(posedge clk);
		chk(tread_internal_ok, 1'b0);
		wb(1'b1, 8'h10, 8'hA5);
		wb(1'b0, 8'h0C, 8'hFF);
		chk(tread_internal_ok, 1'b1);
		wb(1'b1, 8'h0C, 8'hFE);
		wb(1'b0, 8'h0C, 8'h00);
		chk(writer_flash_ok, 1'b0);
		wb(1'b1, 8'h10, 8'hA5);
		chk(writer_flash_ok, 1'b1);
		wb(1'b0, 8'h20, 8'h00);
		writer_req <= 1'b0;
		$display("test security done");
		v = rnd();
		wb(1'b1, 8'h04, v[7:0]);
		chk(flash_bank_select, v[7:0]);
		wb(1'b1, 8'h00, 8'h03);
		wb(1'b0, 8'h00, 8'h03);
		cpu_idle <= 1'b1;
		repeat (2) @(posedge clk);
		chk(boot_from_loader, 1'b1);
		chk(core_restart, 1'b1);
		repeat (4) @(posedge clk);
		chk(core_restart, 1'b0);
		cpu_idle <= 1'b0;
		wb(1'b0, 8'h00, 8'h00);
		wb(1'b1, 8'h00, 8'h83);
		chk(boot_from_loader, 1'b0);
		chk(core_restart, 1'b1);
		chk(flash_bank_select, 8'h00);
		repeat (5) @(posedge clk);
		$display("test switching done");
		wb(1'b1, 8'h00, 8'h01);
		cpu_idle <= 1'b1;
		repeat (2) @(posedge clk);
		chk(flash_update_en, 1'b1);
		chk(core_restart, 1'b0);
		cpu_idle <= 1'b0;
		$display("test update done");
		give_verdict();
	end
endmodule : boot_select_and_code_security_bench
bind bsel_top bsel_properties bsel_properties_i (.clk, .rstn, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .strap_pin_a, .strap_pin_b, .strap_pin_c, .writer_mode,
	.cpu_idle, .tread_from_external, .boot_from_loader, .core_restart,
	.flash_update_en, .flash_bank_select, .tread_internal_ok,
	.writer_flash_ok, .clk_range_high);
`default_nettype wire
